// ===== src/daom_pkg.sv
package daom_pkg;
    // Code width of each channel and of the shared bus
    localparam int CODE_WIDTH = 12;
    // Sample to bus latency in sample clock periods
    localparam int PIPE_LATENCY = 7;
    // Output turn-on delay after the disable input falls
    localparam int TURN_ON_NS = 5;
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int TURN_ON_CYCLES = (TURN_ON_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // Reset values
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [2:0] PIPE_PTR_RESET = 3'h0;
    // Two-entry buffer depth
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        DAOM_OUT_OFF = 2'b00,
        DAOM_OUT_WAKE = 2'b01,
        DAOM_OUT_ON = 2'b10
    } daom_drive_e;
endpackage

// ===== src/daom_pair_buffer.sv
`timescale 1ns/1ps
module daom_pair_buffer (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Fill side: one I/Q pair per word
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [23:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [23:0] out_data
);
    typedef struct packed {
        logic [1:0][23:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } daom_buf_s;

    daom_buf_s state;
    daom_buf_s next_state;
    logic push;
    logic pop;

    assign in_ready = (state.count != 2'(daom_pkg::BUF_DEPTH));
    assign out_valid = (state.count != 2'h0);
    assign out_data = state.mem[state.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_state = state;
        if (push) begin
            next_state.mem[state.wr_ptr] = in_data;
            next_state.wr_ptr = ~state.wr_ptr;
        end
        if (pop) begin
            next_state.rd_ptr = ~state.rd_ptr;
        end
        next_state.count = state.count + 2'(push) - 2'(pop);
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    chk_no_overflow: assert property (@(posedge clock) disable iff (reset)
        state.count <= 2'(daom_pkg::BUF_DEPTH))
        else $error("pair buffer count above depth");
endmodule

// ===== src/daom_output_mux.sv
//
// What this block does
// - Sample both channels together on rising edge
// - Code reaches bus seven periods after sampling
// - Twelve-bit codes share one twelve-line bus
// - Bus updates at rising edge only, no falling-edge Q
// - Disable low: drive all output lines
// - Disable high: float bus, keep converting
// - Re-enable quickly, pipeline never restarts
// - Select high routes I channel codes
// - Select low routes Q channel codes
// - Select passes two sync flops; no I/Q interleave on bus
//
`timescale 1ns/1ps
module daom_output_mux (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Digitised codes from the two converter cores
    input wire logic [11:0] i_code_in,
    input wire logic [11:0] q_code_in,
    // Pins from the capture side
    input wire logic channel_select,
    input wire logic output_disable_n,
    // Shared output bus
    output logic [11:0] sample_code_bus,
    output logic [11:0] sample_code_bus_oe,
    // Buffer stall seen by the pipeline
    output logic pipe_stall
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [1:0] sel_sync;
        logic [1:0] dis_sync;
        logic [6:0][23:0] pipe;
        logic [6:0] pipe_valid;
        logic [23:0] held_pair;
        logic [11:0] bus;
        logic [11:0] oe;
        daom_pkg::daom_drive_e drive;
        logic [2:0] wake_count;
        logic stall;
    } daom_mux_s;

    daom_mux_s state;
    daom_mux_s next_state;
    logic [11:0] q_fall;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [23:0] buf_out_data;

    function automatic logic [11:0] pick_code(input logic [23:0] pair, input logic sel_i);
        pick_code = sel_i ? pair[23:12] : pair[11:0];
    endfunction

    // ****************************************
    // Pipeline into two-entry buffer
    // ****************************************
    // Pipe length plus buffer pop gives exactly seven periods
    daom_pair_buffer u_buffer (
        .clock(clock),
        .reset(reset),
        .in_valid(state.pipe_valid[5]),
        .in_ready(buf_in_ready),
        .in_data(state.pipe[5]),
        .out_valid(buf_out_valid),
        .out_ready(1'b1),
        .out_data(buf_out_data)
    );

    always_comb begin
        next_state = state;
        next_state.sel_sync = {state.sel_sync[0], channel_select};
        next_state.dis_sync = {state.dis_sync[0], output_disable_n};
        // Conversion runs on regardless of bus drive
        next_state.pipe[0] = {i_code_in, q_code_in};
        next_state.pipe_valid[0] = 1'b1;
        for (int k = 1; k < 7; k++) begin
            next_state.pipe[k] = state.pipe[k-1];
            next_state.pipe_valid[k] = state.pipe_valid[k-1];
        end
        next_state.stall = !buf_in_ready;
        if (buf_out_valid) begin
            next_state.held_pair = buf_out_data;
        end
        // Static select: rising edge carries chosen channel
        next_state.bus = pick_code(next_state.held_pair, state.sel_sync[1]);
        case (state.drive)
            daom_pkg::DAOM_OUT_OFF: begin
                if (!state.dis_sync[1]) begin
                    next_state.drive = daom_pkg::DAOM_OUT_WAKE;
                    next_state.wake_count = 3'(daom_pkg::TURN_ON_CYCLES);
                end
            end
            daom_pkg::DAOM_OUT_WAKE: begin
                if (state.dis_sync[1]) begin
                    next_state.drive = daom_pkg::DAOM_OUT_OFF;
                end else if (state.wake_count <= 3'h1) begin
                    next_state.drive = daom_pkg::DAOM_OUT_ON;
                end else begin
                    next_state.wake_count = state.wake_count - 3'h1;
                end
            end
            daom_pkg::DAOM_OUT_ON: begin
                if (state.dis_sync[1]) begin
                    next_state.drive = daom_pkg::DAOM_OUT_OFF;
                end
            end
            default: begin
                next_state.drive = daom_pkg::DAOM_OUT_OFF;
            end
        endcase
        next_state.oe = (next_state.drive == daom_pkg::DAOM_OUT_ON) ? 12'hfff : 12'h000;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Falling-edge Q half, checked but not routed to bus
    // ****************************************
    // Relies on a near 50 percent duty so each half is usable
    always_ff @(negedge clock or posedge reset) begin
        if (reset) begin
            q_fall <= daom_pkg::CODE_RESET;
        end else begin
            q_fall <= state.held_pair[11:0];
        end
    end

    // Bus follows the rising-edge register only; q_fall is not routed out
    assign sample_code_bus = state.bus;
    assign sample_code_bus_oe = state.oe;
    assign pipe_stall = state.stall;

    // ****************************************
    // Checks
    // ****************************************
    // Bus seen here left its register one edge ago, hence depth eight
    chk_bus_latency: assert property (@(posedge clock) disable iff (reset)
        $past(state.pipe_valid[6]) && $past(state.sel_sync[1]) |->
        sample_code_bus == $past(i_code_in, 8))
        else $error("I code not on bus seven periods after sample");
    chk_q_half: assert property (@(posedge clock) disable iff (reset)
        $past(state.pipe_valid[6]) |-> q_fall == state.held_pair[11:0])
        else $error("falling-edge Q half does not follow held pair");
    chk_float_disable: assert property (@(posedge clock) disable iff (reset)
        state.dis_sync[1] |=> sample_code_bus_oe == 12'h000)
        else $error("bus driven while disabled");
    chk_drive_return: assert property (@(posedge clock) disable iff (reset)
        $fell(state.dis_sync[1]) ##1 !state.dis_sync[1] [*3] |->
        sample_code_bus_oe == 12'hfff)
        else $error("bus not driven after enable");
    chk_q_select: assert property (@(posedge clock) disable iff (reset)
        !$past(state.sel_sync[1]) |-> sample_code_bus == state.held_pair[11:0])
        else $error("Q code not routed with select low");
    chk_pipe_runs: assert property (@(posedge clock) disable iff (reset)
        state.pipe[1] == $past(state.pipe[0]))
        else $error("pipeline stalled");
    chk_no_stall: assert property (@(posedge clock) disable iff (reset)
        !pipe_stall)
        else $error("buffer back-pressure in output path");
endmodule

// ===== testbench/daom_capture_model.sv
`timescale 1ns/1ps
module daom_capture_model (
    // Clock
    input wire logic clock,
    // Bus from the converter
    input wire logic [11:0] sample_code_bus,
    input wire logic [11:0] sample_code_bus_oe,
    // Captured word
    output logic [11:0] captured,
    output logic captured_valid
);
    logic [11:0] wire_level;
    // Floating lines show the inverse of the last word, never a stale match
    assign wire_level = (sample_code_bus & sample_code_bus_oe) | (~captured & ~sample_code_bus_oe);
    // Latch at the edge opposite the update
    always_ff @(negedge clock) begin
        captured <= wire_level;
        captured_valid <= &sample_code_bus_oe;
    end
endmodule

// ===== testbench/test_dual_adc_output_mux.sv
`timescale 1ns/1ps
module test_dual_adc_output_mux;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [11:0] i_code_in = 12'h000;
    logic [11:0] q_code_in = 12'h000;
    logic channel_select = 1'b1;
    logic output_disable_n = 1'b0;
    logic [11:0] sample_code_bus, sample_code_bus_oe, captured;
    logic pipe_stall, captured_valid;
    logic checking = 1'b0;
    logic [23:0] note_q[$];
    logic [23:0] note;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    // Even duty cycle
    initial begin
        forever #2.5 clock = ~clock;
    end
    daom_output_mux u_dut (.clock(clock), .reset(reset), .i_code_in(i_code_in),
        .q_code_in(q_code_in), .channel_select(channel_select),
        .output_disable_n(output_disable_n), .sample_code_bus(sample_code_bus),
        .sample_code_bus_oe(sample_code_bus_oe), .pipe_stall(pipe_stall));
    daom_capture_model u_cap (.clock(clock), .sample_code_bus(sample_code_bus),
        .sample_code_bus_oe(sample_code_bus_oe), .captured(captured),
        .captured_valid(captured_valid));
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp_code(logic [11:0] exp);
        checks++;
        if (captured_valid !== 1'b1 || captured !== exp) begin
            num_errors++;
            $display("mismatch code expected %h seen %h", exp, captured);
        end
    endtask
    task automatic cmp_stall(logic exp);
        checks++;
        if (pipe_stall !== exp) begin
            num_errors++;
            $display("mismatch stall expected %b seen %b", exp, pipe_stall);
        end
    endtask
    task automatic cmp_oe(logic [11:0] exp);
        checks++;
        if (sample_code_bus_oe !== exp) begin
            num_errors++;
            $display("mismatch oe expected %h seen %h", exp, sample_code_bus_oe);
        end
    endtask
    // Fresh random pair every cycle, noted in order of sampling
    always @(negedge clock) begin
        logic [11:0] ni, nq;
        ni = 12'($urandom);
        nq = 12'($urandom);
        i_code_in <= ni;
        q_code_in <= nq;
        note_q.push_back({ni, nq});
    end
    // Oldest note leaves once the pipeline depth is covered
    always @(posedge clock) begin
        #1;
        if (note_q.size() > daom_pkg::PIPE_LATENCY + 1) begin
            note = note_q.pop_front();
            if (checking) begin
                cmp_code(channel_select ? note[23:12] : note[11:0]);
                cmp_stall(1'b0);
            end
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(78956));
        repeat (2) @(negedge clock);
        reset <= 1'b0;
        // Select held at each level; sync delay skipped before checking
        for (int s = 1; s >= 0; s--) begin
            checking = 1'b0;
            channel_select <= s[0];
            repeat (12) @(negedge clock);
            checking = 1'b1;
            repeat (40) @(negedge clock);
            $display("select %0d test done", s);
        end
        checking = 1'b0;
        output_disable_n <= 1'b1;
        repeat (6) @(negedge clock);
        cmp_oe(12'h000);
        repeat (20) @(negedge clock);
        output_disable_n <= 1'b0;
        for (int k = 0; k < 8 && sample_code_bus_oe !== 12'hfff; k++) begin
            @(negedge clock);
        end
        cmp_oe(12'hfff);
        // No restart: codes must match at once after re-enable
        checking = 1'b1;
        repeat (30) @(negedge clock);
        $display("disable test done");
        end_sim();
    end
endmodule
